// *** include/omp_pkg.sv ***
// Purpose: constants, types and register map of the operating-mode and paging control
// Assumes: AHB-Lite slave, 32-bit data, one word per register
// Notes:   offsets are byte addresses
package omp_pkg;

    // register byte offsets
    localparam logic [7:0] OMP_CTRL_OFS      = 8'h00;
    localparam logic [7:0] OMP_FLAGS_OFS     = 8'h04;
    localparam logic [7:0] OMP_ROOT_LO_OFS   = 8'h08;
    localparam logic [7:0] OMP_ROOT_HI_OFS   = 8'h0C;
    localparam logic [7:0] OMP_CMD_OFS       = 8'h10;
    localparam logic [7:0] OMP_STATUS_OFS    = 8'h14;
    localparam logic [7:0] OMP_GEOM_OFS      = 8'h18;
    localparam logic [7:0] OMP_ROOT_EFF_LO_OFS = 8'h1C;
    localparam logic [7:0] OMP_ROOT_EFF_HI_OFS = 8'h20;

    // control register field positions
    localparam int OMP_CTRL_PROT_BIT  = 0;   // protected operation enable
    localparam int OMP_CTRL_PAGE_BIT  = 1;   // paging_enable_bit
    localparam int OMP_CTRL_AEXT_BIT  = 2;   // address_extension_enable
    localparam int OMP_CTRL_LPAGE_BIT = 3;   // large_page_enable
    localparam int OMP_CTRL_LME_BIT   = 4;   // long mode enable
    // flags register field position
    localparam int OMP_FLAGS_V86_BIT  = 0;   // virtual_8086_flag
    // command register field positions (write-one pulses)
    localparam int OMP_CMD_MGMT_ENTER = 0;
    localparam int OMP_CMD_MGMT_EXIT  = 1;
    localparam int OMP_CMD_LOAD_CODE  = 2;   // load code descriptor
    localparam int OMP_CMD_LONG_ATTR  = 3;   // long attribute of that descriptor

    // reset values
    localparam logic [4:0]  OMP_CTRL_RST  = 5'h00;
    localparam logic [31:0] OMP_ROOT_RST  = 32'h0000_0000;

    // architectural widths and sizes
    localparam logic [6:0]  OMP_VA_LONG      = 7'h40;  // 64 bits
    localparam logic [6:0]  OMP_VA_LEGACY    = 7'h20;  // 32 bits
    localparam logic [6:0]  OMP_EA_LONG      = 7'h40;
    localparam logic [6:0]  OMP_EA_LEGACY    = 7'h20;
    localparam logic [6:0]  OMP_PA_MAX       = 7'h34;  // 52 bits
    localparam logic [6:0]  OMP_PA_LARGE_DIR = 7'h28;  // 40 bits
    localparam logic [9:0]  OMP_DPT_LONG     = 10'h200; // 512 entries
    localparam logic [9:0]  OMP_DPT_LEGACY   = 10'h004; // 4 entries
    localparam logic [6:0]  OMP_ENTRY_WIDE   = 7'h40;
    localparam logic [6:0]  OMP_ENTRY_NARROW = 7'h20;
    localparam logic [2:0]  OMP_RESTART_BYTES = 3'h1;   // one byte each
    localparam logic [6:0]  OMP_SAVE_WIDTH    = 7'h40;  // 64-bit save layout

    // page-size mask bits
    localparam int OMP_PG_4K = 0;
    localparam int OMP_PG_2M = 1;
    localparam int OMP_PG_4M = 2;

    // translation-root meaning
    typedef enum logic [1:0] {
        OMP_ROOT_NONE    = 2'h0,
        OMP_ROOT_DIR     = 2'h1,   // page-directory table
        OMP_ROOT_DPT     = 2'h2,   // directory_pointer_table
        OMP_ROOT_TOP     = 2'h3    // top_level_map_table
    } omp_root_kind_t;

    // operating modes, one-hot
    typedef enum logic [5:0] {
        OMP_REAL   = 6'h01,
        OMP_PROT   = 6'h02,
        OMP_V86    = 6'h04,
        OMP_COMPAT = 6'h08,
        OMP_LONG64 = 6'h10,
        OMP_MGMT   = 6'h20
    } omp_mode_t;

    // translation geometry reported to the rest of the core
    typedef struct packed {
        logic [6:0]     va_width;
        logic [6:0]     ea_width;
        logic [6:0]     pa_width;
        logic [6:0]     entry_width;
        logic [9:0]     dpt_entries;
        logic [2:0]     levels;
        logic [2:0]     page_sizes;
        omp_root_kind_t root_kind;
        logic           disp_sext64;
    } omp_geom_t;

endpackage

// *** logic/omp_core.sv ***
// Purpose: operating-mode tracking and mode-dependent translation setup
// Assumes: single AHB-Lite slave, word accesses, zero wait states
// Notes:   commands are write-one pulses, unmapped reads return zero, OKAY always
`timescale 1ns/1ps
`default_nettype none
module omp_core
    import omp_pkg::*;
#(
    parameter logic [6:0] PA_IMPL = 7'h34          // implemented physical bits, at most 52
) (
    input  wire logic        hclk,         // core clock
    input  wire logic        hresetn,      // async reset, active low
    input  wire logic        hsel,         // slave select
    input  wire logic [31:0] haddr,        // byte address
    input  wire logic [1:0]  htrans,       // transfer type
    input  wire logic        hwrite,       // write when high
    input  wire logic [2:0]  hsize,        // transfer size
    input  wire logic        hready,       // bus ready in
    input  wire logic [31:0] hwdata,       // write data
    output logic      [31:0] hrdata,       // read data
    output logic             hreadyout,    // always ready
    output logic             hresp,        // always OKAY
    output omp_mode_t        mode,         // current operating mode
    output omp_geom_t        geom,         // translation geometry
    output logic      [63:0] root_eff,     // effective translation root
    output logic             long_active   // long mode active
);

    // address phase capture
    logic       ph_wr;
    logic       ph_rd;
    logic [7:0] ph_addr;
    wire        addr_ok = hsel & hready & htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr   <= 1'b0;
            ph_rd   <= 1'b0;
            ph_addr <= 8'h00;
        end else begin
            ph_wr   <= addr_ok & hwrite;
            ph_rd   <= addr_ok & ~hwrite;
            ph_addr <= haddr[7:0];
        end
    end

    // write strobes per register
    wire wr_ctrl  = ph_wr & (ph_addr == OMP_CTRL_OFS);
    wire wr_flags = ph_wr & (ph_addr == OMP_FLAGS_OFS);
    wire wr_rlo   = ph_wr & (ph_addr == OMP_ROOT_LO_OFS);
    wire wr_rhi   = ph_wr & (ph_addr == OMP_ROOT_HI_OFS);
    wire wr_cmd   = ph_wr & (ph_addr == OMP_CMD_OFS);

    // software-held state
    logic [4:0]  ctrl;
    logic        v86_flag;
    logic [63:0] root;                     // translation_root_register, 64 bits

    wire prot_en  = ctrl[OMP_CTRL_PROT_BIT];
    wire page_en  = ctrl[OMP_CTRL_PAGE_BIT];
    wire aext_en  = ctrl[OMP_CTRL_AEXT_BIT];
    wire lpage_en = ctrl[OMP_CTRL_LPAGE_BIT];
    wire lme      = ctrl[OMP_CTRL_LME_BIT];

    // commands
    wire cmd_enter = wr_cmd & hwdata[OMP_CMD_MGMT_ENTER];
    wire cmd_exit  = wr_cmd & hwdata[OMP_CMD_MGMT_EXIT];
    wire cmd_code  = wr_cmd & hwdata[OMP_CMD_LOAD_CODE];
    wire cmd_lattr = hwdata[OMP_CMD_LONG_ATTR];

    // register storage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl     <= OMP_CTRL_RST;
            v86_flag <= 1'b0;
            root     <= {OMP_ROOT_RST, OMP_ROOT_RST};
        end else begin
            if (wr_ctrl) ctrl <= hwdata[4:0];
            if (wr_flags) v86_flag <= hwdata[OMP_FLAGS_V86_BIT];
            if (wr_rlo) root[31:0] <= hwdata;
            if (wr_rhi) root[63:32] <= hwdata;
        end
    end

    // next values of the control bits as they will stand after this write
    wire [4:0] ctrl_n   = wr_ctrl ? hwdata[4:0] : ctrl;
    wire       v86_n    = wr_flags ? hwdata[OMP_FLAGS_V86_BIT] : v86_flag;
    wire       prot_n   = ctrl_n[OMP_CTRL_PROT_BIT];
    wire       page_n   = ctrl_n[OMP_CTRL_PAGE_BIT];
    wire       aext_n   = ctrl_n[OMP_CTRL_AEXT_BIT];
    wire       lme_n    = ctrl_n[OMP_CTRL_LME_BIT];
    // long mode needs enable, paging, protection and address extension
    wire       long_n   = lme_n & page_n & prot_n & aext_n;

    // mode state machine
    omp_mode_t mode_q;
    omp_mode_t next_mode;
    omp_mode_t ret_mode;                   // mode to resume after management
    omp_mode_t legacy_mode;

    // legacy sub-mode; the virtual-8086 flag has no effect while long mode is enabled
    wire       v86_ok   = v86_n & ~lme_n;
    assign legacy_mode = !prot_n ? OMP_REAL : (v86_ok ? OMP_V86 : OMP_PROT);

    always_comb begin
        next_mode = mode_q;
        case (mode_q)
            OMP_REAL, OMP_PROT, OMP_V86: begin
                if (cmd_enter) next_mode = OMP_MGMT;
                else if (long_n) next_mode = OMP_COMPAT;
                else next_mode = legacy_mode;
            end
            OMP_COMPAT: begin
                if (cmd_enter) next_mode = OMP_MGMT;
                else if (!long_n) next_mode = legacy_mode;
                else if (cmd_code && cmd_lattr) next_mode = OMP_LONG64;
                else next_mode = OMP_COMPAT;
            end
            OMP_LONG64: begin
                if (cmd_enter) next_mode = OMP_MGMT;
                else if (!long_n) next_mode = legacy_mode;
                else if (cmd_code && !cmd_lattr) next_mode = OMP_COMPAT;
                else next_mode = OMP_LONG64;
            end
            OMP_MGMT: begin
                if (cmd_exit) next_mode = ret_mode;
            end
            default: next_mode = OMP_REAL;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q   <= OMP_REAL;
            ret_mode <= OMP_REAL;
        end else begin
            mode_q <= next_mode;
            if (cmd_enter && mode_q != OMP_MGMT) ret_mode <= mode_q;
        end
    end

    // long mode active: compatibility or 64-bit, or management entered from long
    wire in_long  = (mode_q == OMP_COMPAT) | (mode_q == OMP_LONG64);
    wire mgmt_lng = (mode_q == OMP_MGMT) &
                    ((ret_mode == OMP_COMPAT) | (ret_mode == OMP_LONG64));
    wire lng      = in_long | mgmt_lng;
    wire pa_cap   = (PA_IMPL > OMP_PA_MAX) ? 1'b1 : 1'b0;
    wire [6:0] pa_w = pa_cap ? OMP_PA_MAX : PA_IMPL;

    // translation geometry selection
    wire [6:0]  va_w    = lng ? OMP_VA_LONG : OMP_VA_LEGACY;
    wire [6:0]  ea_w    = lng ? OMP_EA_LONG : OMP_EA_LEGACY;
    wire [6:0]  ent_w   = aext_en ? OMP_ENTRY_WIDE : OMP_ENTRY_NARROW;
    wire [9:0]  dpt_n   = lng ? OMP_DPT_LONG : OMP_DPT_LEGACY;
    // four levels only in long mode; legacy has 3 with extension, else 2; none with paging off
    wire [2:0]  lvls    = !page_en ? 3'h0 :
                          lng ? 3'h4 : (aext_en ? 3'h3 : 3'h2);
    // page sizes: long ignores large-page enable
    wire [2:0]  pg_long = (3'h1 << OMP_PG_4K) | (3'h1 << OMP_PG_2M);
    wire [2:0]  pg_ext  = pg_long;
    wire [2:0]  pg_lp   = (3'h1 << OMP_PG_4K) | (3'h1 << OMP_PG_4M);
    wire [2:0]  pg_leg  = aext_en ? pg_ext : (lpage_en ? pg_lp : (3'h1 << OMP_PG_4K));
    wire [2:0]  pg_sel  = !page_en ? 3'h0 : (lng ? pg_long : pg_leg);
    // entry physical width: PA_IMPL capped at 52 with extension, 40 for large directory entry
    wire [6:0]  pa_leg  = aext_en ? pa_w :
                          (lpage_en ? OMP_PA_LARGE_DIR : OMP_VA_LEGACY);
    wire [6:0]  pa_sel  = lng ? pa_w : pa_leg;
    omp_root_kind_t rk;
    assign rk = !page_en ? OMP_ROOT_NONE :
                lng ? OMP_ROOT_TOP :
                (aext_en ? OMP_ROOT_DPT : OMP_ROOT_DIR);
    // upper half of root masked outside long mode
    wire [63:0] root_m  = lng ? root : {32'h0000_0000, root[31:0]};

    omp_geom_t next_geom;
    always_comb begin
        next_geom.va_width    = va_w;
        next_geom.ea_width    = ea_w;
        next_geom.pa_width    = pa_sel;
        next_geom.entry_width = ent_w;
        next_geom.dpt_entries = dpt_n;
        next_geom.levels      = lvls;
        next_geom.page_sizes  = pg_sel;
        next_geom.root_kind   = rk;
        next_geom.disp_sext64 = lng;
    end

    // registered outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            geom        <= '0;
            root_eff    <= 64'h0000_0000_0000_0000;
            long_active <= 1'b0;
        end else begin
            geom        <= next_geom;
            root_eff    <= root_m;
            long_active <= lng;
        end
    end
    assign mode = mode_q;

    // status word: mode, return mode, save layout, restart entry size
    wire [31:0] status_w = {8'h00, OMP_RESTART_BYTES, OMP_SAVE_WIDTH,
                            2'h0, ret_mode, mode_q};
    wire [31:0] geom_w   = {pa_sel, lvls, pg_sel, rk, dpt_n, lng, ent_w[6], va_w[6],
                            ea_w[6], 3'h0};

    // read mux
    logic [31:0] rd_mux;
    always_comb begin
        case (ph_addr)
            OMP_CTRL_OFS:        rd_mux = {27'h0, ctrl};
            OMP_FLAGS_OFS:       rd_mux = {31'h0, v86_flag};
            OMP_ROOT_LO_OFS:     rd_mux = root[31:0];
            OMP_ROOT_HI_OFS:     rd_mux = root[63:32];
            OMP_STATUS_OFS:      rd_mux = status_w;
            OMP_GEOM_OFS:        rd_mux = geom_w;
            OMP_ROOT_EFF_LO_OFS: rd_mux = root_m[31:0];
            OMP_ROOT_EFF_HI_OFS: rd_mux = root_m[63:32];
            default:             rd_mux = 32'h0000_0000;
        endcase
    end

    assign hrdata    = ph_rd ? rd_mux : 32'h0000_0000;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

endmodule
`default_nettype wire

// *** verification/omp_assertions.sv ***
// Purpose: port-level checks of mode tracking and translation geometry
// Assumes: geom, root_eff and long_active lag mode by one cycle
// Notes:   bound to omp_core below
`timescale 1ns/1ps
`default_nettype none
module omp_chk
    import omp_pkg::*;
(
    input wire logic        hclk,        // core clock
    input wire logic        hresetn,     // async reset, active low
    input wire logic        hreadyout,   // slave ready
    input wire logic        hresp,       // slave response
    input wire omp_mode_t   mode,        // current mode
    input wire omp_geom_t   geom,        // geometry
    input wire logic [63:0] root_eff,    // effective root
    input wire logic        long_active  // long mode active
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // mode coding, long-mode consequences, entry width and bus response
    property p_onehot; $onehot(mode); endproperty
    a_onehot: assert property (p_onehot) else $error("mode not one-hot");
    property p_no_real; long_active |-> $past(mode) != OMP_REAL; endproperty
    a_no_real: assert property (p_no_real) else $error("real mode in long");
    property p_activate; (mode == OMP_COMPAT) |=> long_active; endproperty
    a_activate: assert property (p_activate) else $error("long not active");
    property p_widths;
        long_active |-> geom.va_width == OMP_VA_LONG && geom.ea_width == OMP_EA_LONG
                        && geom.disp_sext64;
    endproperty
    a_widths: assert property (p_widths) else $error("long widths wrong");
    property p_pages; long_active |-> geom.page_sizes == 3'h3; endproperty
    a_pages: assert property (p_pages) else $error("long page sizes wrong");
    property p_levels;
        long_active |-> geom.levels == 3'h4 && geom.root_kind == OMP_ROOT_TOP;
    endproperty
    a_levels: assert property (p_levels) else $error("long levels wrong");
    property p_legacy_lv; !long_active |-> geom.levels != 3'h4; endproperty
    a_legacy_lv: assert property (p_legacy_lv) else $error("four levels in legacy");
    property p_dpt; long_active |-> geom.dpt_entries == OMP_DPT_LONG; endproperty
    a_dpt: assert property (p_dpt) else $error("pointer table size wrong");
    property p_mask; !long_active |-> root_eff[63:32] == 32'h0; endproperty
    a_mask: assert property (p_mask) else $error("root upper half unmasked");
    property p_wide; geom.root_kind == OMP_ROOT_DPT |-> geom.entry_width == OMP_ENTRY_WIDE;
    endproperty
    a_wide: assert property (p_wide) else $error("entry not wide");
    property p_bus; hreadyout && !hresp; endproperty
    a_bus: assert property (p_bus) else $error("bus response wrong");
endmodule
bind omp_core omp_chk u_chk (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .mode(mode), .geom(geom), .root_eff(root_eff), .long_active(long_active)
);
`default_nettype wire

// *** verification/tb_operating_mode_and_paging_control.sv ***
// Purpose: self-checking bench of omp_core over its bus
// Assumes: zero-wait slave, mode settles one edge after the data phase
// Notes:   every scenario is one task
`timescale 1ns/1ps
`default_nettype none
module tb_operating_mode_and_paging_control
    import omp_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, long_active;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [63:0] root_eff;
    omp_mode_t   mode;
    omp_geom_t   geom;
    int num_errors, cmp_count, cyc;
    // device under test, hready follows the one slave
    omp_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .mode(mode), .geom(geom), .root_eff(root_eff), .long_active(long_active));
    // clock and hang guard
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            $display("Error %0t: run timed out", $time);
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one single transfer, address phase then data phase
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rdv = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d); xfer(1'b1, a, d); endtask
    task automatic rd(input logic [7:0] a); xfer(1'b0, a, 32'h0); endtask
    task automatic chk_mode(input omp_mode_t m);
        @(posedge hclk);
        chk(32'(mode), 32'(m));
    endtask
    task automatic t_reset();
        chk(32'(mode), 32'(OMP_REAL));
        chk(32'(long_active), 32'h0);
        rd(OMP_STATUS_OFS);
        chk(32'(rdv[5:0]), 32'(OMP_REAL));
        rd(8'h40);
        chk(rdv, 32'h0);
    endtask
    task automatic t_legacy();
        wr(OMP_CTRL_OFS, 32'h13);
        chk_mode(OMP_PROT);
        rd(OMP_GEOM_OFS);
        chk(32'(rdv[18:17]), 32'(OMP_ROOT_DIR));
        chk(32'(rdv[6]), 32'h0);
        wr(OMP_CTRL_OFS, 32'h0B);
        rd(OMP_GEOM_OFS);
        chk(32'(rdv[31:25]), 32'(OMP_PA_LARGE_DIR));
        chk(32'(rdv[19 + OMP_PG_4M]), 32'h1);
        wr(OMP_CTRL_OFS, 32'h07);
        wr(OMP_ROOT_LO_OFS, 32'h1234_5000);
        wr(OMP_ROOT_HI_OFS, 32'hDEAD_BEEF);
        rd(OMP_GEOM_OFS);
        chk(32'(rdv[18:17]), 32'(OMP_ROOT_DPT));
        chk(32'(rdv[5]), 32'h1);
        chk(32'(rdv[16:7]), 32'(OMP_DPT_LEGACY));
        chk(32'(rdv[24:22] == 3'h4), 32'h0);
        chk(32'(rdv[31:25]), 32'(OMP_PA_MAX));
        rd(OMP_ROOT_EFF_HI_OFS);
        chk(rdv, 32'h0);
        chk(root_eff[63:32], 32'h0);
        rd(OMP_ROOT_EFF_LO_OFS);
        chk(rdv, 32'h1234_5000);
    endtask
    task automatic t_long();
        wr(OMP_CTRL_OFS, 32'h1F);
        chk_mode(OMP_COMPAT);
        rd(OMP_GEOM_OFS);
        chk(32'(rdv[21:19]), 32'h3);
        chk(32'(rdv[4:3]), 32'h3);
        chk(32'(rdv[24:22]), 32'h4);
        chk(32'(rdv[16:7]), 32'(OMP_DPT_LONG));
        chk(32'(rdv[18:17]), 32'(OMP_ROOT_TOP));
        rd(OMP_ROOT_EFF_HI_OFS);
        chk(rdv, 32'hDEAD_BEEF);
        chk(root_eff[63:32], 32'hDEAD_BEEF);
        chk(32'(geom.levels), 32'h4);
        wr(OMP_FLAGS_OFS, 32'h1);
        chk_mode(OMP_COMPAT);
        wr(OMP_CMD_OFS, 32'h0C);
        chk_mode(OMP_LONG64);
        wr(OMP_CMD_OFS, 32'h01);
        chk_mode(OMP_MGMT);
        rd(OMP_STATUS_OFS);
        chk(32'(rdv[20:14]), 32'(OMP_SAVE_WIDTH));
        chk(32'(rdv[23:21]), 32'h1);
        wr(OMP_CMD_OFS, 32'h02);
        chk_mode(OMP_LONG64);
        wr(OMP_CMD_OFS, 32'h04);
        chk_mode(OMP_COMPAT);
        wr(OMP_FLAGS_OFS, 32'h0);
        wr(OMP_CTRL_OFS, 32'h1D);
        chk_mode(OMP_PROT);
        @(posedge hclk);
        chk(32'(long_active), 32'h0);
    endtask
    task automatic t_mgmt_legacy();
        wr(OMP_CMD_OFS, 32'h02);
        chk_mode(OMP_PROT);
        wr(OMP_CMD_OFS, 32'h01);
        chk_mode(OMP_MGMT);
        wr(OMP_CMD_OFS, 32'h02);
        chk_mode(OMP_PROT);
        wr(OMP_FLAGS_OFS, 32'h1);
        chk_mode(OMP_PROT);
        wr(OMP_CTRL_OFS, 32'h01);
        chk_mode(OMP_V86);
    endtask
    // reset, then the scenarios in order
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
        hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
        num_errors = 0; cmp_count = 0; cyc = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_legacy();
        t_long();
        t_mgmt_legacy();
        tally_and_finish();
    end
endmodule
`default_nettype wire
